// file: tpg_pkg.sv
// package of constants and types for the pattern generator and verifier
package tpg_pkg;

  typedef enum logic [2:0] {
    TPG_MODE_BIST   = 3'h0,
    TPG_MODE_PRBS7  = 3'h1,
    TPG_MODE_PRBS8  = 3'h2,
    TPG_MODE_PRBS10 = 3'h3,
    TPG_MODE_PRBS23 = 3'h4,
    TPG_MODE_HIFREQ = 3'h5,
    TPG_MODE_LOFREQ = 3'h6
  } tpg_mode_t;

  localparam int unsigned TPG_BIST_W = 16;
  localparam int unsigned TPG_WORD_W = 20;
  localparam int unsigned TPG_LFSR_W = 23;

  // polynomial tap positions (1-based exponents)
  localparam int unsigned TPG_P7_A = 7;
  localparam int unsigned TPG_P7_B = 6;
  localparam int unsigned TPG_P8_A = 8;
  localparam int unsigned TPG_P8_B = 7;
  localparam int unsigned TPG_P10_A = 10;
  localparam int unsigned TPG_P10_B = 7;
  localparam int unsigned TPG_P23_A = 23;
  localparam int unsigned TPG_P23_B = 18;

  // serial bits per parallel word in the prbs modes
  localparam logic [4:0] TPG_BITS_8 = 5'h08;
  localparam logic [4:0] TPG_BITS_10 = 5'h0a;

  // word alignment patterns
  localparam logic [15:0] TPG_ALIGN_PRBS7 = 16'h3040;
  localparam logic [15:0] TPG_ALIGN_PRBS8 = 16'hff5a;
  localparam logic [9:0] TPG_ALIGN_PRBS10 = 10'h3ff;
  localparam logic [15:0] TPG_ALIGN_PRBS23 = 16'hffff;

  localparam logic [TPG_LFSR_W-1:0] TPG_SEED = 23'h7fffff;
  localparam logic [7:0] TPG_BYTE_LAST = 8'hff;
  // last fill word index before prbs checking; the extra words flush
  // out whatever the receive path held before the loop settled
  localparam logic [7:0] TPG_PRBS_FILL = 8'h07;
  localparam logic [TPG_WORD_W-1:0] TPG_HI_PAT = 20'haaaaa;
  localparam logic [TPG_WORD_W-1:0] TPG_LO_SW = 20'h7c1f;
  localparam logic [TPG_WORD_W-1:0] TPG_LO_DW = 20'h003ff;

  typedef enum logic [1:0] {
    TPG_VS_IDLE = 2'h0,
    TPG_VS_RUN  = 2'h1,
    TPG_VS_DONE = 2'h3
  } tpg_vstate_t;

endpackage

// file: tpg_lfsr_if.sv
// interface carrying lfsr step requests between the pattern blocks
`timescale 1ns/1ps
`default_nettype none
interface tpg_lfsr_if;
  tpg_pkg::tpg_mode_t mode;
  logic [tpg_pkg::TPG_LFSR_W-1:0] state_in;
  logic [tpg_pkg::TPG_LFSR_W-1:0] state_out;
  logic [tpg_pkg::TPG_WORD_W-1:0] bits_out;
  modport user (output mode, output state_in, input state_out,
                input bits_out);
  modport stepper (input mode, input state_in, output state_out,
                   output bits_out);
endinterface
`default_nettype wire

// file: tpg_lfsr_step.sv
// combinational lfsr advance by one parallel word for every prbs mode
`timescale 1ns/1ps
`default_nettype none
module tpg_lfsr_step (
  tpg_lfsr_if.stepper s
);
  always_comb begin
    logic [tpg_pkg::TPG_LFSR_W-1:0] st;
    logic fb;
    int unsigned ta;
    int unsigned tb;
    int unsigned nb;
    ta = tpg_pkg::TPG_P23_A;
    tb = tpg_pkg::TPG_P23_B;
    nb = 8;
    st = s.state_in;
    fb = 1'b0;
    s.bits_out = '0;
    case (s.mode)
      tpg_pkg::TPG_MODE_PRBS7: begin
        ta = tpg_pkg::TPG_P7_A;
        tb = tpg_pkg::TPG_P7_B;
        nb = 8;
      end
      tpg_pkg::TPG_MODE_PRBS8: begin
        ta = tpg_pkg::TPG_P8_A;
        tb = tpg_pkg::TPG_P8_B;
        nb = 8;
      end
      tpg_pkg::TPG_MODE_PRBS10: begin
        ta = tpg_pkg::TPG_P10_A;
        tb = tpg_pkg::TPG_P10_B;
        nb = 10;
      end
      default: begin
        ta = tpg_pkg::TPG_P23_A;
        tb = tpg_pkg::TPG_P23_B;
        nb = 8;
      end
    endcase
    // fibonacci form, one bit per iteration, msb of word sent first
    for (int i = 0; i < 10; i++) begin
      if (i < nb) begin
        fb = st[ta-1] ^ st[tb-1];
        s.bits_out[nb-1-i] = fb;
        st = {st[tpg_pkg::TPG_LFSR_W-2:0], fb};
        // keep bits above the polynomial order clear
        for (int k = 0; k < tpg_pkg::TPG_LFSR_W; k++) begin
          if (k >= ta) begin
            st[k] = 1'b0;
          end
        end
      end
    end
    s.state_out = st;
  end
endmodule
`default_nettype wire

// file: tpg_top.sv
// per-channel bist and prbs pattern generator with matching verifier
`timescale 1ns/1ps
`default_nettype none
module tpg_top #(
  parameter tpg_pkg::tpg_mode_t MODE = tpg_pkg::TPG_MODE_BIST,
  parameter bit DOUBLE_WIDTH = 1'b0
) (
  input wire logic core_clk_i,
  input wire logic reset_n_i,
  input wire logic tx_pcs_reset_i,
  input wire logic rx_pcs_reset_i,
  input wire logic rx_analog_reset_i,
  input wire logic pll_powerdown_i,
  input wire logic serial_loopback_en_i,
  input wire logic [tpg_pkg::TPG_WORD_W-1:0] rx_aligned_data_i,
  output logic [tpg_pkg::TPG_WORD_W-1:0] tx_serial_word_o,
  output logic [tpg_pkg::TPG_WORD_W-1:0] rx_fabric_data_o,
  output logic serial_loopback_o,
  output logic [15:0] align_pattern_o,
  output logic verify_done_o,
  output logic verify_error_o
);

  // mode is a parameter, fixed at build time
  localparam bit IS_BIST = (MODE == tpg_pkg::TPG_MODE_BIST);
  localparam bit IS_SQ = (MODE == tpg_pkg::TPG_MODE_HIFREQ) ||
                         (MODE == tpg_pkg::TPG_MODE_LOFREQ);
  localparam bit IS_PRBS = !IS_BIST && !IS_SQ;

  typedef struct packed {
    logic [tpg_pkg::TPG_LFSR_W-1:0] gen_lfsr;
    logic [tpg_pkg::TPG_LFSR_W-1:0] ver_lfsr;
    logic [7:0] gen_byte;
    logic [7:0] exp_byte;
    logic [tpg_pkg::TPG_WORD_W-1:0] sq_word;
    logic [tpg_pkg::TPG_WORD_W-1:0] tx_word;
    logic [tpg_pkg::TPG_WORD_W-1:0] rx_fab;
    logic [tpg_pkg::TPG_BIST_W-1:0] loop_word;
    logic loop_vld;
    logic lpbk;
    tpg_pkg::tpg_vstate_t vstate;
    logic done;
    logic err;
  } tpg_state_t;

  tpg_state_t st_r;
  tpg_state_t st_nxt;

  tpg_lfsr_if gen_if ();
  tpg_lfsr_if ver_if ();

  tpg_lfsr_step u_gen_step (
    .s(gen_if.stepper)
  );
  tpg_lfsr_step u_ver_step (
    .s(ver_if.stepper)
  );

  assign gen_if.mode = MODE;
  assign gen_if.state_in = st_r.gen_lfsr;
  assign ver_if.mode = MODE;
  assign ver_if.state_in = st_r.ver_lfsr;

  // reset hold of the flags during pll power-down, and outside bist also during rx analog reset
  logic flag_hold;
  assign flag_hold = IS_BIST ? pll_powerdown_i :
                     (pll_powerdown_i || rx_analog_reset_i);

  logic [tpg_pkg::TPG_WORD_W-1:0] rx_bits;
  logic [9:0] rx_cmp;
  logic prbs_bad;
  logic [7:0] lb_hi;
  logic [7:0] lb_lo;
  logic bist_bad;

  always_comb begin
    rx_bits = rx_aligned_data_i;
    rx_cmp = IS_PRBS && (MODE == tpg_pkg::TPG_MODE_PRBS10) ?
             rx_bits[9:0] : {2'h0, rx_bits[7:0]};
    prbs_bad = (rx_cmp != ver_if.bits_out[9:0]);
    lb_hi = st_r.loop_word[15:8];
    lb_lo = st_r.loop_word[7:0];
    bist_bad = (lb_hi != st_r.exp_byte) ||
               (lb_lo != 8'(st_r.exp_byte + 8'h01));
  end

  always_comb begin
    st_nxt = st_r;
    st_nxt.lpbk = IS_PRBS && serial_loopback_en_i;

    // generator side
    if (tx_pcs_reset_i) begin
      st_nxt.gen_lfsr = tpg_pkg::TPG_SEED;
      st_nxt.gen_byte = 8'h00;
      st_nxt.sq_word = DOUBLE_WIDTH ? tpg_pkg::TPG_LO_DW :
                       tpg_pkg::TPG_LO_SW;
      st_nxt.tx_word = '0;
      st_nxt.loop_vld = 1'b0;
    end else if (IS_BIST) begin
      // two incrementing bytes per 16-bit word, 00..ff wraps
      st_nxt.gen_byte = 8'(st_r.gen_byte + 8'h02);
      st_nxt.tx_word = {4'h0, st_r.gen_byte,
                        8'(st_r.gen_byte + 8'h01)};
      st_nxt.loop_word = {st_r.gen_byte, 8'(st_r.gen_byte + 8'h01)};
      st_nxt.loop_vld = 1'b1;
    end else if (IS_PRBS) begin
      st_nxt.gen_lfsr = gen_if.state_out;
      st_nxt.tx_word = gen_if.bits_out;
    end else if (MODE == tpg_pkg::TPG_MODE_HIFREQ) begin
      st_nxt.tx_word = DOUBLE_WIDTH ? tpg_pkg::TPG_HI_PAT :
                       {10'h000, tpg_pkg::TPG_HI_PAT[9:0]};
    end else begin
      // the word holds whole run pairs, so repeating it keeps runs unbroken
      st_nxt.tx_word = DOUBLE_WIDTH ? st_r.sq_word :
                       {10'h000, st_r.sq_word[9:0]};
    end

    // rx fabric data never shows the bist loopback
    st_nxt.rx_fab = IS_BIST ? '0 : rx_aligned_data_i;

    // verifier side
    if (rx_pcs_reset_i) begin
      st_nxt.ver_lfsr = tpg_pkg::TPG_SEED;
      st_nxt.exp_byte = 8'h00;
      st_nxt.vstate = tpg_pkg::TPG_VS_IDLE;
      if (!flag_hold) begin
        st_nxt.done = 1'b0;
        st_nxt.err = 1'b0;
      end
    end else if (IS_SQ) begin
      st_nxt.done = 1'b0;
      st_nxt.err = 1'b0;
    end else if (IS_BIST) begin
      case (st_r.vstate)
        tpg_pkg::TPG_VS_IDLE: begin
          // lock on the first word that starts the byte cycle
          if (st_r.loop_vld && lb_hi == 8'h00) begin
            st_nxt.exp_byte = 8'h02;
            st_nxt.vstate = tpg_pkg::TPG_VS_RUN;
          end
        end
        tpg_pkg::TPG_VS_RUN: begin
          st_nxt.exp_byte = 8'(st_r.exp_byte + 8'h02);
          if (bist_bad) begin
            st_nxt.err = 1'b1;
            st_nxt.done = 1'b1;
            st_nxt.vstate = tpg_pkg::TPG_VS_DONE;
          end else if (lb_lo == tpg_pkg::TPG_BYTE_LAST) begin
            st_nxt.done = 1'b1;
            st_nxt.vstate = tpg_pkg::TPG_VS_DONE;
          end
        end
        tpg_pkg::TPG_VS_DONE: begin
          // keep checking so later errors still show
          st_nxt.exp_byte = 8'(st_r.exp_byte + 8'h02);
          if (bist_bad) begin
            st_nxt.err = 1'b1;
          end
        end
        default: st_nxt.vstate = tpg_pkg::TPG_VS_IDLE;
      endcase
    end else begin
      // self-synchronising: seed the checker from received bits
      case (st_r.vstate)
        tpg_pkg::TPG_VS_IDLE: begin
          // one word is too short for prbs23, so gather several
          if (MODE == tpg_pkg::TPG_MODE_PRBS10) begin
            st_nxt.ver_lfsr = {st_r.ver_lfsr[12:0], rx_cmp};
          end else begin
            st_nxt.ver_lfsr = {st_r.ver_lfsr[14:0], rx_cmp[7:0]};
          end
          st_nxt.exp_byte = 8'(st_r.exp_byte + 8'h01);
          if (st_r.exp_byte == tpg_pkg::TPG_PRBS_FILL) begin
            st_nxt.vstate = tpg_pkg::TPG_VS_RUN;
          end
        end
        tpg_pkg::TPG_VS_RUN, tpg_pkg::TPG_VS_DONE: begin
          st_nxt.ver_lfsr = ver_if.state_out;
          if (prbs_bad) begin
            st_nxt.err = 1'b1;
            st_nxt.done = 1'b1;
            st_nxt.vstate = tpg_pkg::TPG_VS_DONE;
          end
        end
        default: st_nxt.vstate = tpg_pkg::TPG_VS_IDLE;
      endcase
    end
  end

  always_ff @(posedge core_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      st_r <= '{gen_lfsr: tpg_pkg::TPG_SEED, ver_lfsr: tpg_pkg::TPG_SEED,
               gen_byte: 8'h00, exp_byte: 8'h00,
               sq_word: DOUBLE_WIDTH ? tpg_pkg::TPG_LO_DW :
               tpg_pkg::TPG_LO_SW,
               tx_word: '0, rx_fab: '0,
               loop_word: '0, loop_vld: 1'b0, lpbk: 1'b0,
               vstate: tpg_pkg::TPG_VS_IDLE, done: 1'b0, err: 1'b0};
    end else begin
      st_r <= st_nxt;
    end
  end

  // alignment pattern is a static per-mode constant, registered
  logic [15:0] align_r;
  always_ff @(posedge core_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      align_r <= 16'h0000;
    end else begin
      case (MODE)
        tpg_pkg::TPG_MODE_PRBS7: begin
          align_r <= tpg_pkg::TPG_ALIGN_PRBS7;
        end
        tpg_pkg::TPG_MODE_PRBS8: begin
          align_r <= tpg_pkg::TPG_ALIGN_PRBS8;
        end
        tpg_pkg::TPG_MODE_PRBS10: begin
          align_r <= {6'h00, tpg_pkg::TPG_ALIGN_PRBS10};
        end
        tpg_pkg::TPG_MODE_PRBS23: begin
          align_r <= tpg_pkg::TPG_ALIGN_PRBS23;
        end
        default: align_r <= 16'h0000;
      endcase
    end
  end

  assign tx_serial_word_o = st_r.tx_word;
  assign rx_fabric_data_o = st_r.rx_fab;
  assign serial_loopback_o = st_r.lpbk;
  assign align_pattern_o = align_r;
  assign verify_done_o = st_r.done;
  assign verify_error_o = st_r.err;

  property p_err_sticky;
    @(posedge core_clk_i) disable iff (!reset_n_i)
      verify_error_o && !(rx_pcs_reset_i && !flag_hold) |=> verify_error_o;
  endproperty
  a_err_sticky: assert property (p_err_sticky)
    else $error("error flag dropped without verifier reset");

  property p_done_sticky;
    @(posedge core_clk_i) disable iff (!reset_n_i)
      verify_done_o && !rx_pcs_reset_i |=> verify_done_o;
  endproperty
  a_done_sticky: assert property (p_done_sticky)
    else $error("done flag dropped");

  property p_err_implies_done;
    @(posedge core_clk_i) disable iff (!reset_n_i)
      verify_error_o |-> verify_done_o;
  endproperty
  a_err_implies_done: assert property (p_err_implies_done)
    else $error("error without done");

  property p_hold_flags;
    @(posedge core_clk_i) disable iff (!reset_n_i)
      rx_pcs_reset_i && flag_hold && verify_done_o |=> verify_done_o;
  endproperty
  a_hold_flags: assert property (p_hold_flags)
    else $error("flags cleared during power-down");

  property p_clear_flags;
    @(posedge core_clk_i) disable iff (!reset_n_i)
      rx_pcs_reset_i && !flag_hold |=> !verify_done_o && !verify_error_o;
  endproperty
  a_clear_flags: assert property (p_clear_flags)
    else $error("verifier reset did not clear flags");

  property p_no_fabric_bist;
    @(posedge core_clk_i) disable iff (!reset_n_i)
      IS_BIST |-> rx_fabric_data_o == '0;
  endproperty
  a_no_fabric_bist: assert property (p_no_fabric_bist)
    else $error("bist data leaked to fabric");

  property p_sq_no_flags;
    @(posedge core_clk_i) disable iff (!reset_n_i)
      IS_SQ && !rx_pcs_reset_i |=> !verify_done_o && !verify_error_o;
  endproperty
  a_sq_no_flags: assert property (p_sq_no_flags)
    else $error("square pattern raised a flag");

  property p_bist_incr;
    @(posedge core_clk_i) disable iff (!reset_n_i)
      IS_BIST && !tx_pcs_reset_i ##1 !tx_pcs_reset_i ##1 !tx_pcs_reset_i |=>
        tx_serial_word_o[15:8] == 8'($past(tx_serial_word_o[15:8]) + 8'h02);
  endproperty
  a_bist_incr: assert property (p_bist_incr)
    else $error("bist bytes not incrementing");

  property p_lpbk;
    @(posedge core_clk_i) disable iff (!reset_n_i)
      serial_loopback_en_i |=> serial_loopback_o == IS_PRBS;
  endproperty
  a_lpbk: assert property (p_lpbk)
    else $error("loopback enable not followed");

  property p_lpbk_off;
    @(posedge core_clk_i) disable iff (!reset_n_i)
      !serial_loopback_en_i |=> !serial_loopback_o;
  endproperty
  a_lpbk_off: assert property (p_lpbk_off)
    else $error("loopback stayed on after enable dropped");

  property p_tx_reset_clear;
    @(posedge core_clk_i) disable iff (!reset_n_i)
      tx_pcs_reset_i |=> tx_serial_word_o == '0;
  endproperty
  a_tx_reset_clear: assert property (p_tx_reset_clear)
    else $error("generator not cleared by tx reset");

  property p_bist_done_at_end;
    @(posedge core_clk_i) disable iff (!reset_n_i)
      IS_BIST && st_r.vstate == tpg_pkg::TPG_VS_RUN &&
      lb_lo == tpg_pkg::TPG_BYTE_LAST && !bist_bad && !rx_pcs_reset_i
      |=> verify_done_o;
  endproperty
  a_bist_done_at_end: assert property (p_bist_done_at_end)
    else $error("done not raised after full byte cycle");

  property p_prbs_err_on_bad;
    @(posedge core_clk_i) disable iff (!reset_n_i)
      IS_PRBS && st_r.vstate != tpg_pkg::TPG_VS_IDLE && prbs_bad &&
      !rx_pcs_reset_i |=> verify_error_o && verify_done_o;
  endproperty
  a_prbs_err_on_bad: assert property (p_prbs_err_on_bad)
    else $error("prbs mismatch did not raise the flags");

endmodule
`default_nettype wire

// file: tpg_loop_model.sv
// far-side model: serializer, word aligner and serial loopback path
`timescale 1ns/1ps
`default_nettype none
module tpg_loop_model (
  input wire logic clk_i,
  input wire logic loop_en_i,
  input wire logic corrupt_i,
  input wire logic [tpg_pkg::TPG_WORD_W-1:0] tx_word_i,
  output logic [tpg_pkg::TPG_WORD_W-1:0] rx_word_o
);
  // aligned words come back one cycle after they were sent
  initial begin
    rx_word_o = '0;
    forever begin
      @(posedge clk_i);
      if (loop_en_i) begin
        rx_word_o <= tx_word_i ^ {19'h0, corrupt_i};
      end else begin
        // released path: toggle so stale data never looks valid
        rx_word_o <= ~rx_word_o;
      end
    end
  end
endmodule
`default_nettype wire

// file: tb.sv
// self-checking bench for the pattern generator and verifier
`timescale 1ns/1ps
`default_nettype none
module tb;
  localparam int W = tpg_pkg::TPG_WORD_W;
  typedef struct {
    logic [15:0] align;
    int w;
    int tap_a;
    int tap_b;
    int e;
    bit lb;
    bit flg;
  } tpg_row_t;
  logic core_clk;
  logic reset_n;
  logic tx_rst;
  logic rx_rst;
  logic ana_rst;
  logic pll_pd;
  logic lb_en;
  logic [7:0] corrupt;
  int bad_count = 0;
  int check_count = 0;
  int k;
  wire logic [W-1:0] tx_w [8];
  wire logic [W-1:0] rx_w [8];
  wire logic [W-1:0] fab_w [8];
  wire logic [15:0] al [8];
  wire logic lb_o [8];
  wire logic done [8];
  wire logic err [8];
  // one channel per mode, plus a last double-width lofreq channel
  tpg_row_t rows [8] = '{
    '{16'h0000, 16, 0, 0, 0, 1'b0, 1'b0},
    '{16'h3040, 8, 7, 6, 0, 1'b1, 1'b1},
    '{16'hff5a, 8, 8, 7, 0, 1'b1, 1'b1},
    '{16'h03ff, 10, 10, 7, 0, 1'b1, 1'b1},
    '{16'hffff, 8, 23, 18, 0, 1'b1, 1'b1},
    '{16'h0000, 10, 1, 0, 1, 1'b0, 1'b1},
    '{16'h0000, 10, 5, 0, 1, 1'b0, 1'b1},
    '{16'h0000, 20, 10, 0, 1, 1'b0, 1'b1}};

  for (genvar g = 0; g < 8; g++) begin : g_ch
    localparam tpg_pkg::tpg_mode_t M =
      tpg_pkg::tpg_mode_t'((g == 7) ? 6 : g);
    tpg_top #(.MODE(M), .DOUBLE_WIDTH(g == 7)) DUT (
      .core_clk_i(core_clk),
      .reset_n_i(reset_n),
      .tx_pcs_reset_i(tx_rst),
      .rx_pcs_reset_i(rx_rst),
      .rx_analog_reset_i(ana_rst),
      .pll_powerdown_i(pll_pd),
      .serial_loopback_en_i(lb_en),
      .rx_aligned_data_i(rx_w[g]),
      .tx_serial_word_o(tx_w[g]),
      .rx_fabric_data_o(fab_w[g]),
      .serial_loopback_o(lb_o[g]),
      .align_pattern_o(al[g]),
      .verify_done_o(done[g]),
      .verify_error_o(err[g])
    );
    tpg_loop_model u_loop (
      .clk_i(core_clk),
      .loop_en_i(lb_o[g]),
      .corrupt_i(corrupt[g]),
      .tx_word_i(tx_w[g]),
      .rx_word_o(rx_w[g])
    );
  end

  initial begin
    core_clk = 1'b0;
    forever #12.5 core_clk = ~core_clk;
  end

  task automatic check(input logic [W-1:0] seen, input logic [W-1:0] exp);
    check_count++;
    if (seen !== exp) begin
      bad_count++;
      $display("MISMATCH t=%0t seen %h exp %h", $time, seen, exp);
    end
  endtask

  task automatic wrap_up();
    $display("checks %0d mismatches %0d", check_count, bad_count);
    if (bad_count == 0 && check_count > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  // serial stream is msb first per word, checked across word edges
  task automatic run_row(input int i);
    logic q [$];
    logic [W-1:0] prev;
    logic v;
    int bad;
    bad = 0;
    prev = rx_w[i];
    repeat (40) begin
      @(negedge core_clk);
      check(fab_w[i], (i == 0) ? '0 : prev);
      for (int b = rows[i].w - 1; b >= 0; b--) q.push_back(tx_w[i][b]);
      prev = rx_w[i];
    end
    check({4'h0, al[i]}, {4'h0, rows[i].align});
    check(lb_o[i], rows[i].lb);
    if (rows[i].flg) begin
      check(done[i], 1'b0);
      check(err[i], 1'b0);
    end
    if (rows[i].tap_a > 0) begin
      for (int n = 23; n < q.size(); n++) begin
        v = q[n] ^ q[n - rows[i].tap_a];
        if (rows[i].tap_b > 0) v = v ^ q[n - rows[i].tap_b];
        if (v !== rows[i].e[0]) bad++;
      end
      check(20'(bad), '0);
    end
  endtask

  initial begin
    reset_n = 1'b0;
    tx_rst = 1'b0;
    rx_rst = 1'b0;
    ana_rst = 1'b0;
    pll_pd = 1'b0;
    lb_en = 1'b1;
    corrupt = '0;
    repeat (10) @(negedge core_clk);
    for (int i = 0; i < 8; i++) check(tx_w[i] | done[i], '0);
    repeat (10) @(posedge core_clk);
    reset_n <= 1'b1;
    @(negedge core_clk);
    for (int i = 0; i < 8; i++) run_row(i);
    // restart bist: tx reset for the generator, rx reset for the verifier
    @(posedge core_clk);
    tx_rst <= 1'b1;
    rx_rst <= 1'b1;
    @(posedge core_clk);
    tx_rst <= 1'b0;
    rx_rst <= 1'b0;
    @(negedge core_clk);
    check(done[0], 1'b0);
    k = 0;
    while (tx_w[0][15:0] !== 16'h0001 && k < 4) begin
      @(negedge core_clk);
      k++;
    end
    for (int n = 0; n < 128; n++) begin
      check(tx_w[0][15:0], {8'(2 * n), 8'(2 * n + 1)});
      if (n < 120) check(done[0], 1'b0);
      @(negedge core_clk);
    end
    k = 0;
    while (done[0] !== 1'b1 && k < 10) begin
      @(negedge core_clk);
      k++;
    end
    check(done[0], 1'b1);
    check(err[0], 1'b0);
    // one bad bit on the prbs7 loop
    @(posedge core_clk);
    corrupt[1] <= 1'b1;
    @(posedge core_clk);
    corrupt[1] <= 1'b0;
    repeat (6) @(negedge core_clk);
    check(err[1], 1'b1);
    check(done[1], 1'b1);
    check(err[2], 1'b0);
    // rx reset under pll power-down, then under analog reset alone
    for (int h = 0; h < 2; h++) begin
      @(posedge core_clk);
      pll_pd <= (h == 0);
      ana_rst <= (h == 1);
      rx_rst <= 1'b1;
      @(posedge core_clk);
      rx_rst <= 1'b0;
      pll_pd <= 1'b0;
      ana_rst <= 1'b0;
      repeat (3) @(negedge core_clk);
      check(err[1], 1'b1);
      check(done[1], 1'b1);
      check(done[0], h == 0);
    end
    @(posedge core_clk);
    rx_rst <= 1'b1;
    @(posedge core_clk);
    rx_rst <= 1'b0;
    repeat (20) @(negedge core_clk);
    check(err[1], 1'b0);
    check(done[1], 1'b0);
    @(posedge core_clk);
    lb_en <= 1'b0;
    repeat (2) @(negedge core_clk);
    for (int i = 0; i < 8; i++) check(lb_o[i], 1'b0);
    wrap_up();
  end

  // whole run needs well under a thousand cycles
  initial begin
    repeat (5000) @(posedge core_clk);
    bad_count++;
    $display("MISMATCH t=%0t watchdog expired", $time);
    wrap_up();
  end
endmodule
`default_nettype wire
